// file: verilog/timer_regs.vh
// Register offsets, fields, reset values and mode constants of the timer
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
// ==========================================
// Register byte offsets
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_CMP_A 8'h08
`define OFF_CMP_B 8'h0C
`define OFF_CAPTURE 8'h10
`define OFF_COUNT 8'h14
`define OFF_STATUS 8'h18
`define OFF_MASK 8'h1C
`define OFF_PRESCALE 8'h20
// ==========================================
// Fields
`define WM_LOW_MSB 1
`define WM_LOW_LSB 0
`define WM_HIGH_MSB 4
`define WM_HIGH_LSB 3
`define CLK_EN_BIT 0
`define ST_OVF 0
`define ST_MATCH_A 1
`define ST_MATCH_B 2
`define ST_W 3
// ==========================================
// Reset values and fixed limits
`define RST_16 16'h0000
`define TOP_MAX 16'hFFFF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define PRESCALE_RST 16'h0000
// ==========================================
// Source of TOP
`define TSRC_FIXED 2'd0
`define TSRC_CMP_A 2'd1
`define TSRC_CAPTURE 2'd2
// Update and overflow points
`define PT_IMMED 2'd0
`define PT_TOP 2'd1
`define PT_BOTTOM 2'd2
`define PT_MAX 2'd3
`endif

// file: verilog/wave_mode_decode.v
// Decoder from the four-bit waveform mode to counting behaviour
`timescale 1ns/1ns
`include "timer_regs.vh"
module wave_mode_decode (
	// Mode in
	input wire [3:0] wave_mode,
	// Decoded behaviour
	output reg [15:0] fixed_top,
	output reg [1:0] top_source,
	output reg [1:0] update_point,
	output reg [1:0] overflow_point,
	output reg dual_slope
);
	always @* begin
		fixed_top = `TOP_MAX;
		top_source = `TSRC_FIXED;
		update_point = `PT_IMMED;
		overflow_point = `PT_MAX;
		dual_slope = 1'b0;
		case (wave_mode)
			4'd0: begin
				fixed_top = `TOP_MAX;
			end
			4'd1, 4'd2, 4'd3: begin
				fixed_top = (wave_mode == 4'd1) ? `TOP_8 : (wave_mode == 4'd2) ? `TOP_9 : `TOP_10;
				dual_slope = 1'b1;
				update_point = `PT_TOP;
				overflow_point = `PT_BOTTOM;
			end
			4'd4: begin
				top_source = `TSRC_CMP_A;
			end
			4'd5, 4'd6, 4'd7: begin
				fixed_top = (wave_mode == 4'd5) ? `TOP_8 : (wave_mode == 4'd6) ? `TOP_9 : `TOP_10;
				update_point = `PT_TOP;
				overflow_point = `PT_TOP;
			end
			4'd8, 4'd9: begin
				top_source = wave_mode[0] ? `TSRC_CMP_A : `TSRC_CAPTURE;
				dual_slope = 1'b1;
				update_point = `PT_BOTTOM;
				overflow_point = `PT_BOTTOM;
			end
			4'd10, 4'd11: begin
				top_source = wave_mode[0] ? `TSRC_CMP_A : `TSRC_CAPTURE;
				dual_slope = 1'b1;
				update_point = `PT_TOP;
				overflow_point = `PT_BOTTOM;
			end
			4'd12: begin
				top_source = `TSRC_CAPTURE;
			end
			4'd14, 4'd15: begin
				top_source = wave_mode[0] ? `TSRC_CMP_A : `TSRC_CAPTURE;
				update_point = `PT_TOP;
				overflow_point = `PT_TOP;
			end
			default: begin
				fixed_top = `TOP_MAX;
			end
		endcase
	end
endmodule

// file: verilog/timer_wave_mode.v
// Sixteen-bit timer with waveform mode decode and AXI4-Lite registers
// How it works
// - The mode is the two low bits of control A joined with bits 4 and 3 of control B as its high bits.
// - Mode 0 counts up to 0xFFFF, loads compare writes at once and flags overflow at MAX.
// - Modes 4 and 12 take TOP from compare A or capture, load at once and flag overflow at MAX.
// - Modes 1, 2 and 3 count up and down with TOP 0x00FF, 0x01FF and 0x03FF.
// - Those fixed phase correct modes update compares at TOP and flag overflow at BOTTOM.
// - Modes 5 to 7 count up only and update compares and flag overflow at TOP.
// - Modes 8 and 9 take TOP from capture or compare A and update and flag at BOTTOM.
// - Modes 10 and 11 take TOP from capture or compare A, update at TOP and flag at BOTTOM.
// - Modes 14 and 15 take TOP from capture or compare A and update and flag at TOP.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "timer_regs.vh"
module timer_wave_mode (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// Write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// Write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// Read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// Read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Events
	output reg irq
);
	// ==========================================
	// Registers
	reg [7:0] ctrl_a_r;
	reg [7:0] ctrl_b_r;
	reg [15:0] cmp_a_buf_r;
	reg [15:0] cmp_b_buf_r;
	reg [15:0] cmp_a_r;
	reg [15:0] cmp_b_r;
	reg [15:0] capture_r;
	reg [15:0] count_r;
	reg count_down_r;
	reg [`ST_W-1:0] status_r;
	reg [`ST_W-1:0] mask_r;
	reg [15:0] prescale_r;
	reg [15:0] pre_cnt_r;
	reg tick_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg aw_have_r;
	reg w_have_r;
	// ==========================================
	// Mode decode
	wire [3:0] wave_mode;
	wire [15:0] fixed_top;
	wire [1:0] top_source;
	wire [1:0] update_point;
	wire [1:0] overflow_point;
	wire dual_slope;
	assign wave_mode = {ctrl_b_r[`WM_HIGH_MSB:`WM_HIGH_LSB], ctrl_a_r[`WM_LOW_MSB:`WM_LOW_LSB]};
	wave_mode_decode u_decode (
		.wave_mode(wave_mode),
		.fixed_top(fixed_top),
		.top_source(top_source),
		.update_point(update_point),
		.overflow_point(overflow_point),
		.dual_slope(dual_slope)
	);
	// ==========================================
	// Counter sequence
	reg [15:0] top_val;
	reg [15:0] count_nxt;
	reg down_nxt;
	reg at_top;
	reg at_bottom;
	reg at_max;
	reg update_now;
	reg ovf_now;
	always @* begin
		case (top_source)
			`TSRC_CMP_A: top_val = cmp_a_r;
			`TSRC_CAPTURE: top_val = capture_r;
			default: top_val = fixed_top;
		endcase
	end
	always @* begin
		count_nxt = count_r;
		down_nxt = count_down_r;
		at_top = 1'b0;
		at_bottom = 1'b0;
		at_max = 1'b0;
		if (tick_r) begin
			if (dual_slope) begin
				if (count_down_r) begin
					if (count_r == `RST_16 || count_r > top_val) begin
						down_nxt = 1'b0;
						count_nxt = (count_r == `RST_16) ? 16'h0001 : `RST_16;
					end else begin
						count_nxt = count_r - 16'h0001;
						at_bottom = (count_nxt == `RST_16);
					end
				end else if (count_r >= top_val) begin
					down_nxt = 1'b1;
					count_nxt = (count_r == `RST_16) ? `RST_16 : count_r - 16'h0001;
				end else begin
					count_nxt = count_r + 16'h0001;
					at_top = (count_nxt == top_val);
				end
			end else begin
				down_nxt = 1'b0;
				if (count_r == top_val) begin
					count_nxt = `RST_16;
					at_bottom = 1'b1;
				end else begin
					count_nxt = count_r + 16'h0001;
					at_top = (count_nxt == top_val);
				end
				at_max = (count_nxt == `TOP_MAX) && (count_r != top_val);
			end
		end
		case (update_point)
			`PT_TOP: update_now = at_top;
			`PT_BOTTOM: update_now = at_bottom;
			default: update_now = 1'b1;
		endcase
		case (overflow_point)
			`PT_TOP: ovf_now = at_top;
			`PT_BOTTOM: ovf_now = at_bottom;
			default: ovf_now = at_max;
		endcase
	end
	// ==========================================
	// Bus helpers
	wire aw_take;
	wire w_take;
	wire do_write;
	wire ar_take;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	wire wr_ctrl_a = do_write && awaddr_r == `OFF_CTRL_A && wstrb_r[0];
	wire wr_ctrl_b = do_write && awaddr_r == `OFF_CTRL_B && wstrb_r[0];
	wire wr_cmp_a = do_write && awaddr_r == `OFF_CMP_A;
	wire wr_cmp_b = do_write && awaddr_r == `OFF_CMP_B;
	wire wr_cap = do_write && awaddr_r == `OFF_CAPTURE;
	wire wr_cnt = do_write && awaddr_r == `OFF_COUNT;
	wire wr_stat = do_write && awaddr_r == `OFF_STATUS && wstrb_r[0];
	wire wr_mask = do_write && awaddr_r == `OFF_MASK && wstrb_r[0];
	wire wr_pre = do_write && awaddr_r == `OFF_PRESCALE;
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] d;
		input [3:0] s;
		begin
			merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
		end
	endfunction
	wire [15:0] cmp_a_wval = merge16(cmp_a_buf_r, wdata_r, wstrb_r);
	wire [15:0] cmp_b_wval = merge16(cmp_b_buf_r, wdata_r, wstrb_r);
	wire immed = (update_point == `PT_IMMED);
	// ==========================================
	// Match events
	wire match_a = tick_r && (count_nxt == cmp_a_r);
	wire match_b = tick_r && (count_nxt == cmp_b_r);
	wire [`ST_W-1:0] events = {match_b, match_a, ovf_now};
	// ==========================================
	// Timer state
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_a_r <= 8'h00;
			ctrl_b_r <= 8'h00;
			cmp_a_buf_r <= `RST_16;
			cmp_b_buf_r <= `RST_16;
			cmp_a_r <= `RST_16;
			cmp_b_r <= `RST_16;
			capture_r <= `RST_16;
			count_r <= `RST_16;
			count_down_r <= 1'b0;
			status_r <= {`ST_W{1'b0}};
			mask_r <= {`ST_W{1'b0}};
			prescale_r <= `PRESCALE_RST;
			pre_cnt_r <= `RST_16;
			tick_r <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (ctrl_b_r[`CLK_EN_BIT] && pre_cnt_r >= prescale_r) begin
				pre_cnt_r <= `RST_16;
				tick_r <= 1'b1;
			end else begin
				pre_cnt_r <= ctrl_b_r[`CLK_EN_BIT] ? pre_cnt_r + 16'h0001 : `RST_16;
				tick_r <= 1'b0;
			end
			if (wr_ctrl_a)
				ctrl_a_r <= wdata_r[7:0];
			if (wr_ctrl_b)
				ctrl_b_r <= wdata_r[7:0];
			if (wr_cap)
				capture_r <= merge16(capture_r, wdata_r, wstrb_r);
			if (wr_pre)
				prescale_r <= merge16(prescale_r, wdata_r, wstrb_r);
			if (wr_mask)
				mask_r <= wdata_r[`ST_W-1:0];
			if (wr_cmp_a)
				cmp_a_buf_r <= cmp_a_wval;
			if (wr_cmp_b)
				cmp_b_buf_r <= cmp_b_wval;
			if (immed) begin
				cmp_a_r <= wr_cmp_a ? cmp_a_wval : cmp_a_buf_r;
				cmp_b_r <= wr_cmp_b ? cmp_b_wval : cmp_b_buf_r;
			end else if (update_now) begin
				cmp_a_r <= cmp_a_buf_r;
				cmp_b_r <= cmp_b_buf_r;
			end
			if (wr_cnt) begin
				count_r <= merge16(count_r, wdata_r, wstrb_r);
			end else begin
				count_r <= count_nxt;
				count_down_r <= down_nxt;
			end
			// Set wins over write-one-to-clear
			status_r <= (status_r & ~(wr_stat ? wdata_r[`ST_W-1:0] : {`ST_W{1'b0}})) | events;
			irq <= |(((status_r & ~(wr_stat ? wdata_r[`ST_W-1:0] : {`ST_W{1'b0}})) | events) & mask_r);
		end
	end
	// ==========================================
	// AXI4-Lite write
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			s_axi_awready <= !aw_have_r && !aw_take && !s_axi_bvalid;
			s_axi_wready <= !w_have_r && !w_take && !s_axi_bvalid;
			if (aw_take) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_r[1:0] == 2'b00 && awaddr_r <= `OFF_PRESCALE) ? 2'b00 : 2'b10;
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ==========================================
	// AXI4-Lite read
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
					`OFF_CTRL_A: s_axi_rdata <= {24'h00_0000, ctrl_a_r};
					`OFF_CTRL_B: s_axi_rdata <= {24'h00_0000, ctrl_b_r};
					`OFF_CMP_A: s_axi_rdata <= {16'h0000, cmp_a_buf_r};
					`OFF_CMP_B: s_axi_rdata <= {16'h0000, cmp_b_buf_r};
					`OFF_CAPTURE: s_axi_rdata <= {16'h0000, capture_r};
					`OFF_COUNT: s_axi_rdata <= {16'h0000, count_r};
					`OFF_STATUS: s_axi_rdata <= {{(32-`ST_W){1'b0}}, status_r};
					`OFF_MASK: s_axi_rdata <= {{(32-`ST_W){1'b0}}, mask_r};
					`OFF_PRESCALE: s_axi_rdata <= {16'h0000, prescale_r};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// file: tb/timer_wave_mode_monitor.sv
// Bus checker for the timer register port
`timescale 1ns/1ns
module timer_wave_mode_monitor (
	// Clock and reset
	input logic aclk,
	input logic aresetn,
	// Write side
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	// Read side
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	write_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid) else $error("no write response");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
	read_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("no read data");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
	read_unmapped_a: assert property (rd_take ##0 (s_axi_araddr >= 8'h24) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
		else $error("unmapped read not refused");
	write_unmapped_a: assert property (wr_both ##0 (s_axi_awaddr >= 8'h24) |-> ##2 s_axi_bresp == 2'h2)
		else $error("unmapped write not refused");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
endmodule
bind timer_wave_mode timer_wave_mode_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: tb/timer_wave_mode_tb.sv
// Mode decode bench for the timer
`timescale 1ns/1ns
`include "timer_regs.vh"
module timer_wave_mode_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, cnt;
	logic [3:0] s_axi_wstrb, md;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] top;
	int err_total, checks;
	timer_wave_mode u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	// ==========================================
	// Tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 100);
		if (n >= 100) err_total++;
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 100);
		if (n >= 100) err_total++;
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task set_mode(input logic [3:0] m);
		md = m;
		wr(`OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
		wr(`OFF_CTRL_A, {30'h0, m[1:0]});
	endtask
	// Preset count to one below t, run the clock for cyc cycles, read count and status
	task run_mode(input logic [15:0] t, input int cyc);
		wr(`OFF_COUNT, {16'h0000, t - 16'h0001});
		wr(`OFF_STATUS, 32'h0000_0007);
		wr(`OFF_CTRL_B, {27'h0, md[3:2], 3'h1});
		repeat (cyc) @(posedge aclk);
		wr(`OFF_CTRL_B, {27'h0, md[3:2], 3'h0});
		rd(`OFF_COUNT);
		cnt = rd_v;
		rd(`OFF_STATUS);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================
	// Clock, watchdog and tests
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		#300000;
		err_total++;
		finish_test;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		rd(`OFF_COUNT);
		chk("count reset", rd_v, 32'h0000_0000);
		rd(`OFF_STATUS);
		chk("status reset", rd_v, 32'h0000_0000);
		rd(8'h40);
		chk("bad read", {rsp, rd_v[29:0]}, 32'h8000_0000);
		wr(8'h40, 32'h0000_1234);
		chk("bad write", {30'h0, rsp}, 32'h0000_0002);
		wr(`OFF_CMP_A, 32'h0000_0040);
		wr(`OFF_CAPTURE, 32'h0000_0080);
		for (int m = 0; m < 16; m++) begin
			case (m)
				0, 13: top = 16'hFFFF;
				1, 5: top = 16'h00FF;
				2, 6: top = 16'h01FF;
				3, 7: top = 16'h03FF;
				4, 9, 11, 15: top = 16'h0040;
				default: top = 16'h0080;
			endcase
			set_mode(m[3:0]);
			rd(`OFF_CTRL_A);
			chk("mode low", rd_v, {30'h0, md[1:0]});
			run_mode(top, 4);
			if (m inside {1, 2, 3, 8, 9, 10, 11}) chk("dual", {31'h0, cnt < top && cnt + 16 > top}, 1);
			else chk("wrap", {31'h0, cnt < 32'h0000_0010}, 1);
			chk("ovf flag", {31'h0, rd_v[0]}, {31'h0, m inside {0, 5, 6, 7, 13, 14, 15}});
		end
		set_mode(4'hE);
		wr(`OFF_CMP_A, 32'h0000_0010);
		run_mode(16'h000A, 4);
		chk("match held", {31'h0, rd_v[1]}, 0);
		rd(`OFF_CMP_A);
		chk("cmp buffer", rd_v, 32'h0000_0010);
		set_mode(4'h0);
		wr(`OFF_CMP_A, 32'h0000_0010);
		run_mode(16'h000A, 4);
		chk("match now", {31'h0, rd_v[1]}, 1);
		chk("irq masked", {31'h0, irq}, 0);
		wr(`OFF_MASK, 32'h0000_0002);
		repeat (2) @(posedge aclk);
		chk("irq on", {31'h0, irq}, 1);
		wr(`OFF_STATUS, 32'h0000_0002);
		repeat (2) @(posedge aclk);
		chk("irq off", {31'h0, irq}, 0);
		// ==========================================
		// Dual slope modes run long enough to count up to TOP and back down to BOTTOM
		set_mode(4'h9);
		run_mode(16'h0006, 40);
		chk("ovf bottom 9", {31'h0, rd_v[0]}, 1);
		set_mode(4'hB);
		run_mode(16'h0006, 40);
		chk("ovf bottom 11", {31'h0, rd_v[0]}, 1);
		set_mode(4'h1);
		run_mode(16'h0006, 600);
		chk("ovf bottom 1", {31'h0, rd_v[0]}, 1);
		finish_test;
	end
endmodule
